// ===== src/asrs_regs.sv
// Behaviour
// R01: operating state read-only, codes 0..3, reset 0
// R02: bit 1 shows right channel auto-mute
// R03: bit 0 shows left channel auto-mute
// R04: two-bit ramp phase select, 45 degree steps
// R05: host sets phase before entering play
// R06: sync source bit: 0 GPIO, 1 internal
// R07: bit 0 enables phase sync, reset off
// R08: pre-divide bit picks PLL clock over two
// R09: manual bit puts spread controller manual
// R10: triangle frequency and range field, reset 0
// R11: manual ramp divider N, reset 0xa0
// R12: falling step field bits 7:4, reset 1
// R13: rising step field bits 3:0, reset 1
// R14: period boundary field bits 4:0, reset 4
// R15: amplitude field bits 6:5, reset 1
// R16: read-only writes ignored, reserved hold reset
`include "asrs_map.svh"
`default_nettype none
module asrs_regs (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // control port register access
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output var asrs_pkg::asrs_byte_t regRdData,
  // device state inputs, same clock
  input wire logic [7:0] opStateIn,
  input wire logic leftMuteIn,
  input wire logic rightMuteIn,
  // ramp phase controls
  output var logic [1:0] rampPhaseSel,
  output var logic phaseSyncInternal,
  output var logic phaseSyncEn,
  // spread-spectrum controls
  output var logic triangleSpreadOn,
  output var logic randomSpreadOn,
  output var logic spreadManual,
  output var logic spreadPreDiv,
  output var asrs_pkg::asrs_ssmode_e spreadMode,
  output var logic [2:0] ditherAmount,
  output var logic [3:0] triangleTrimCode,
  output var logic [7:0] manualFreqDivisor,
  output var logic [3:0] triangleFallStep,
  output var logic [3:0] triangleRiseStep,
  output var logic [4:0] trianglePeriodLimit,
  output var logic [1:0] rampAmplitude
);
  import asrs_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    asrs_byte_t opState;
    logic [1:0] mute;
    asrs_byte_t phase;
    asrs_byte_t ss0;
    asrs_byte_t ss1;
    asrs_byte_t ss2;
    asrs_byte_t ss3;
    asrs_byte_t ss4;
    asrs_byte_t rd;
    asrs_ssmode_e mode;
  } asrs_state_s;

  asrs_state_s state_q;
  asrs_state_s state_d;

  // masked write keeps reserved bits at their reset value
  function automatic asrs_byte_t maskWr(input asrs_byte_t cur,
      input asrs_byte_t wr, input asrs_byte_t msk);
    maskWr = (wr & msk) | (cur & ~msk);
  endfunction

  function automatic asrs_ssmode_e modeOf(input asrs_byte_t ss0);
    if (ss0[`ASRS_SS0_MAN])
      modeOf = ASRS_SS_MANUAL;
    else if (ss0[`ASRS_SS0_TRI] | ss0[`ASRS_SS0_RDM])
      modeOf = ASRS_SS_AUTO;
    else
      modeOf = ASRS_SS_OFF;
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    // reserved codes are not reported; last legal code holds
    if (opStateIn <= `ASRS_OP_STATE_MAX) begin
      state_d.opState = opStateIn; // R01
    end
    state_d.mute = {rightMuteIn, leftMuteIn}; // R02 R03
    if (regWrEn) begin
      case (regAddr)
        `ASRS_OFF_PHASE: begin
          // R04 R06 R07
          state_d.phase = maskWr(state_q.phase, regWrData,
              `ASRS_MASK_PHASE);
        end
        `ASRS_OFF_SS0: begin
          // R08 R09
          state_d.ss0 = maskWr(state_q.ss0, regWrData,
              `ASRS_MASK_SS0);
        end
        `ASRS_OFF_SS1: begin
          // R10
          state_d.ss1 = maskWr(state_q.ss1, regWrData,
              `ASRS_MASK_SS1);
        end
        `ASRS_OFF_SS2: begin
          state_d.ss2 = regWrData; // R11
        end
        `ASRS_OFF_SS3: begin
          state_d.ss3 = regWrData; // R12 R13
        end
        `ASRS_OFF_SS4: begin
          // R14 R15
          state_d.ss4 = maskWr(state_q.ss4, regWrData,
              `ASRS_MASK_SS4);
        end
        default: begin
          // R16
          state_d.ss4 = state_q.ss4;
        end
      endcase
    end
    state_d.mode = modeOf(state_d.ss0); // R09
    case (regAddr)
      `ASRS_OFF_DIE: state_d.rd = `ASRS_DIE_CODE;
      `ASRS_OFF_PWR: state_d.rd = state_d.opState;
      `ASRS_OFF_MUTE: state_d.rd = {6'h0, state_d.mute};
      `ASRS_OFF_PHASE: state_d.rd = state_d.phase;
      `ASRS_OFF_SS0: state_d.rd = state_d.ss0;
      `ASRS_OFF_SS1: state_d.rd = state_d.ss1;
      `ASRS_OFF_SS2: state_d.rd = state_d.ss2;
      `ASRS_OFF_SS3: state_d.rd = state_d.ss3;
      `ASRS_OFF_SS4: state_d.rd = state_d.ss4;
      default: state_d.rd = `ASRS_RD_UNMAPPED;
    endcase
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_q.opState <= `ASRS_RST_OPSTATE;
      state_q.mute <= `ASRS_RST_MUTE;
      state_q.phase <= `ASRS_RST_PHASE;
      state_q.ss0 <= `ASRS_RST_SS0;
      state_q.ss1 <= `ASRS_RST_SS1;
      state_q.ss2 <= `ASRS_RST_SS2;
      state_q.ss3 <= `ASRS_RST_SS3;
      state_q.ss4 <= `ASRS_RST_SS4;
      state_q.rd <= `ASRS_RST_RD;
      state_q.mode <= ASRS_SS_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  assign regRdData = state_q.rd;
  assign rampPhaseSel =
      state_q.phase[`ASRS_PH_SEL_HI:`ASRS_PH_SEL_LO]; // R04
  assign phaseSyncInternal = state_q.phase[`ASRS_PH_SYNC_SRC]; // R06
  assign phaseSyncEn = state_q.phase[`ASRS_PH_SYNC_EN]; // R07
  assign triangleSpreadOn = state_q.ss0[`ASRS_SS0_TRI];
  assign randomSpreadOn = state_q.ss0[`ASRS_SS0_RDM];
  assign spreadManual = state_q.ss0[`ASRS_SS0_MAN]; // R09
  // pre-divide only meaningful in manual mode
  assign spreadPreDiv = state_q.ss0[`ASRS_SS0_PREDIV]; // R08
  assign spreadMode = state_q.mode;
  assign ditherAmount =
      state_q.ss1[`ASRS_SS1_DITH_HI:`ASRS_SS1_DITH_LO];
  assign triangleTrimCode =
      state_q.ss1[`ASRS_SS1_TRIM_HI:`ASRS_SS1_TRIM_LO]; // R10
  assign manualFreqDivisor = state_q.ss2; // R11
  assign triangleFallStep =
      state_q.ss3[`ASRS_SS3_FALL_HI:`ASRS_SS3_FALL_LO]; // R12
  assign triangleRiseStep =
      state_q.ss3[`ASRS_SS3_RISE_HI:`ASRS_SS3_RISE_LO]; // R13
  assign trianglePeriodLimit =
      state_q.ss4[`ASRS_SS4_LIM_HI:`ASRS_SS4_LIM_LO]; // R14
  assign rampAmplitude =
      state_q.ss4[`ASRS_SS4_AMP_HI:`ASRS_SS4_AMP_LO]; // R15

  // ==========================================================
  // checks
  op_state_legal_a: assert property ( // R01
    @(posedge mclk) disable iff (!rst_b)
    state_q.opState <= `ASRS_OP_STATE_MAX)
    else $error("reserved operating state reported");
  right_mute_track_a: assert property ( // R02
    @(posedge mclk) disable iff (!rst_b)
    ##1 state_q.mute[1] == $past(rightMuteIn))
    else $error("right mute flag wrong");
  left_mute_track_a: assert property ( // R03
    @(posedge mclk) disable iff (!rst_b)
    ##1 state_q.mute[0] == $past(leftMuteIn))
    else $error("left mute flag wrong");
  phase_write_a: assert property ( // R04
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_PHASE
    |=> rampPhaseSel == $past(regWrData[`ASRS_PH_SEL_HI:`ASRS_PH_SEL_LO]))
    else $error("phase select not written");
  sync_src_write_a: assert property ( // R06
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_PHASE
    |=> phaseSyncInternal == $past(regWrData[`ASRS_PH_SYNC_SRC]))
    else $error("sync source not written");
  sync_en_write_a: assert property ( // R07
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_PHASE
    |=> phaseSyncEn == $past(regWrData[`ASRS_PH_SYNC_EN]))
    else $error("sync enable not written");
  prediv_write_a: assert property ( // R08
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_SS0
    |=> spreadPreDiv == $past(regWrData[`ASRS_SS0_PREDIV]))
    else $error("pre-divide not written");
  manual_mode_a: assert property ( // R09
    @(posedge mclk) disable iff (!rst_b)
    spreadManual == (spreadMode == ASRS_SS_MANUAL))
    else $error("manual mode mismatch");
  divisor_hold_a: assert property ( // R11
    @(posedge mclk) disable iff (!rst_b)
    !(regWrEn && regAddr == `ASRS_OFF_SS2) |=> $stable(manualFreqDivisor))
    else $error("divisor changed without write");
  step_write_a: assert property ( // R12
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_SS3
    |=> {triangleFallStep, triangleRiseStep} == $past(regWrData))
    else $error("step fields not written");
  reserved_zero_a: assert property ( // R16
    @(posedge mclk) disable iff (!rst_b)
    (state_q.phase & ~`ASRS_MASK_PHASE) == 8'h00 &&
    (state_q.ss0 & ~`ASRS_MASK_SS0) == 8'h00 &&
    (state_q.ss1 & ~`ASRS_MASK_SS1) == 8'h00 &&
    (state_q.ss4 & ~`ASRS_MASK_SS4) == 8'h00)
    else $error("reserved bit changed");
  mute_read_a: assert property ( // R16
    @(posedge mclk) disable iff (!rst_b)
    regAddr == `ASRS_OFF_MUTE ##1 regAddr == `ASRS_OFF_MUTE
    |-> (regRdData & ~`ASRS_MASK_MUTE) == 8'h00)
    else $error("mute reserved bits nonzero");

  // ==========================================================
  // status report checks
  op_state_track_a: assert property ( // R01
    @(posedge mclk) disable iff (!rst_b)
    opStateIn <= `ASRS_OP_STATE_MAX
    |=> state_q.opState == $past(opStateIn))
    else $error("operating state not tracked");
  op_state_hold_a: assert property ( // R01
    @(posedge mclk) disable iff (!rst_b)
    opStateIn > `ASRS_OP_STATE_MAX |=> $stable(state_q.opState))
    else $error("reserved operating state taken");
  state_read_a: assert property ( // R01
    @(posedge mclk) disable iff (!rst_b)
    regAddr == `ASRS_OFF_PWR |=> regRdData == state_q.opState)
    else $error("operating state read wrong");
  die_read_a: assert property ( // R16
    @(posedge mclk) disable iff (!rst_b)
    regAddr == `ASRS_OFF_DIE |=> regRdData == `ASRS_DIE_CODE)
    else $error("identifier read wrong");

  // ==========================================================
  // control write and spread mode decode checks
  mode_auto_a: assert property ( // R09
    @(posedge mclk) disable iff (!rst_b)
    !spreadManual && (triangleSpreadOn || randomSpreadOn)
    |-> spreadMode == ASRS_SS_AUTO)
    else $error("auto mode not decoded");
  trim_write_a: assert property ( // R10
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_SS1
    |=> triangleTrimCode ==
        $past(regWrData[`ASRS_SS1_TRIM_HI:`ASRS_SS1_TRIM_LO]))
    else $error("trim field not written");
  divisor_write_a: assert property ( // R11
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_SS2
    |=> manualFreqDivisor == $past(regWrData))
    else $error("divisor not written");
  rise_write_a: assert property ( // R13
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_SS3
    |=> triangleRiseStep ==
        $past(regWrData[`ASRS_SS3_RISE_HI:`ASRS_SS3_RISE_LO]))
    else $error("rise step not written");
  limit_write_a: assert property ( // R14
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_SS4
    |=> trianglePeriodLimit ==
        $past(regWrData[`ASRS_SS4_LIM_HI:`ASRS_SS4_LIM_LO]))
    else $error("period limit not written");
  amp_write_a: assert property ( // R15
    @(posedge mclk) disable iff (!rst_b)
    regWrEn && regAddr == `ASRS_OFF_SS4
    |=> rampAmplitude ==
        $past(regWrData[`ASRS_SS4_AMP_HI:`ASRS_SS4_AMP_LO]))
    else $error("amplitude not written");

  // ==========================================================
  // reset value checks
  // only the first cycle out of reset; later writes may move them
  reset_vals_a: assert property ( // R04 R07 R10 R11 R12 R13 R14 R15
    @(posedge mclk) disable iff (!rst_b)
    !$past(rst_b)
    |-> state_q.phase == `ASRS_RST_PHASE &&
        state_q.ss0 == `ASRS_RST_SS0 &&
        state_q.ss1 == `ASRS_RST_SS1 &&
        state_q.ss2 == `ASRS_RST_SS2 &&
        state_q.ss3 == `ASRS_RST_SS3 &&
        state_q.ss4 == `ASRS_RST_SS4)
    else $error("register not at reset value");
endmodule
`default_nettype wire

// ===== src/asrs_map.svh
`ifndef ASRS_MAP_SVH
`define ASRS_MAP_SVH
// ==========================================================
// register offsets
`define ASRS_OFF_DIE 8'h67
`define ASRS_OFF_PWR 8'h68
`define ASRS_OFF_MUTE 8'h69
`define ASRS_OFF_PHASE 8'h6a
`define ASRS_OFF_SS0 8'h6b
`define ASRS_OFF_SS1 8'h6c
`define ASRS_OFF_SS2 8'h6d
`define ASRS_OFF_SS3 8'h6e
`define ASRS_OFF_SS4 8'h6f
// ==========================================================
// reset values
// die code value is arbitrary, chosen for this block only
`define ASRS_DIE_CODE 8'h5a
`define ASRS_RST_OPSTATE 8'h00
`define ASRS_RST_MUTE 2'h0
`define ASRS_RST_RD 8'h00
`define ASRS_RD_UNMAPPED 8'h00
`define ASRS_RST_PHASE 8'h00
`define ASRS_RST_SS0 8'h00
`define ASRS_RST_SS1 8'h00
`define ASRS_RST_SS2 8'ha0
`define ASRS_RST_SS3 8'h11
`define ASRS_RST_SS4 8'h24
// ==========================================================
// field positions, writable masks, mute read mask and operating state limit
`define ASRS_PH_SYNC_EN 0
`define ASRS_PH_SYNC_SRC 1
`define ASRS_PH_SEL_LO 2
`define ASRS_PH_SEL_HI 3
`define ASRS_SS0_TRI 0
`define ASRS_SS0_RDM 1
`define ASRS_SS0_MAN 4
`define ASRS_SS0_PREDIV 5
`define ASRS_MASK_PHASE 8'h0f
`define ASRS_MASK_SS0 8'h33
`define ASRS_MASK_SS1 8'h7f
`define ASRS_MASK_SS4 8'h7f
`define ASRS_OP_STATE_MAX 8'h03
`define ASRS_MASK_MUTE 8'h03
`define ASRS_SS1_DITH_HI 6
`define ASRS_SS1_DITH_LO 4
`define ASRS_SS1_TRIM_HI 3
`define ASRS_SS1_TRIM_LO 0
`define ASRS_SS3_FALL_HI 7
`define ASRS_SS3_FALL_LO 4
`define ASRS_SS3_RISE_HI 3
`define ASRS_SS3_RISE_LO 0
`define ASRS_SS4_LIM_HI 4
`define ASRS_SS4_LIM_LO 0
`define ASRS_SS4_AMP_HI 6
`define ASRS_SS4_AMP_LO 5
`endif

// ===== src/asrs_pkg.sv
`default_nettype none
package asrs_pkg;
  typedef logic [7:0] asrs_byte_t;
  typedef enum logic [1:0] {
    ASRS_SS_OFF,
    ASRS_SS_AUTO,
    ASRS_SS_MANUAL
  } asrs_ssmode_e;
endpackage
`default_nettype wire

// ===== tb/asrs_regs_tb.sv
`include "asrs_map.svh"
`default_nettype none
module asrs_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // design hookup
  logic mclk, rst_b, regWrEn, leftMuteIn, rightMuteIn;
  logic [7:0] regAddr, regWrData, opStateIn, manualFreqDivisor;
  asrs_pkg::asrs_byte_t regRdData;
  asrs_pkg::asrs_ssmode_e spreadMode;
  logic [1:0] rampPhaseSel, rampAmplitude;
  logic phaseSyncInternal, phaseSyncEn, triangleSpreadOn;
  logic randomSpreadOn, spreadManual, spreadPreDiv;
  logic [2:0] ditherAmount;
  logic [3:0] triangleTrimCode, triangleFallStep, triangleRiseStep;
  logic [4:0] trianglePeriodLimit;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  asrs_regs dut (.mclk, .rst_b, .regWrEn, .regAddr, .regWrData,
    .regRdData, .opStateIn, .leftMuteIn, .rightMuteIn, .rampPhaseSel,
    .phaseSyncInternal, .phaseSyncEn, .triangleSpreadOn, .randomSpreadOn,
    .spreadManual, .spreadPreDiv, .spreadMode, .ditherAmount,
    .triangleTrimCode, .manualFreqDivisor, .triangleFallStep,
    .triangleRiseStep, .trianglePeriodLimit, .rampAmplitude);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ==========================================================
  // helpers
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe stays up so back-to-back writes never retoggle it
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge mclk);
  endtask
  task automatic rd(string what, logic [7:0] a, logic [7:0] exp);
    regWrEn = 1'b0;
    regAddr = a;
    @(negedge mclk);
    chk(what, exp, regRdData);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset_vals();
    rd("die", `ASRS_OFF_DIE, `ASRS_DIE_CODE);
    rd("state", `ASRS_OFF_PWR, 8'h00);
    rd("mute", `ASRS_OFF_MUTE, 8'h00);
    rd("phase", `ASRS_OFF_PHASE, 8'h00);
    rd("ss0", `ASRS_OFF_SS0, 8'h00);
    rd("ss1", `ASRS_OFF_SS1, 8'h00);
    rd("ss2", `ASRS_OFF_SS2, 8'ha0);
    rd("ss3", `ASRS_OFF_SS3, 8'h11);
    rd("ss4", `ASRS_OFF_SS4, 8'h24);
    chk("limit", 8'h04, {3'h0, trianglePeriodLimit});
    chk("amp", 8'h01, {6'h0, rampAmplitude});
  endtask
  task automatic t_status();
    for (int i = 0; i < 4; i++) begin
      opStateIn = 8'(i);
      @(negedge mclk);
      rd("state", `ASRS_OFF_PWR, 8'(i));
      {rightMuteIn, leftMuteIn} = 2'(i);
      @(negedge mclk);
      rd("mute", `ASRS_OFF_MUTE, 8'(i));
    end
    opStateIn = 8'h07;
    @(negedge mclk);
    rd("state", `ASRS_OFF_PWR, 8'h03);
  endtask
  task automatic t_readonly();
    wr(`ASRS_OFF_DIE, 8'hff);
    wr(`ASRS_OFF_PWR, 8'hff);
    wr(`ASRS_OFF_MUTE, 8'h00);
    wr(8'h70, 8'hff);
    rd("die", `ASRS_OFF_DIE, `ASRS_DIE_CODE);
    rd("state", `ASRS_OFF_PWR, 8'h03);
    rd("mute", `ASRS_OFF_MUTE, 8'h03);
    rd("unmapped", 8'h70, 8'h00);
  endtask
  task automatic t_phase();
    opStateIn = 8'h02;
    wr(`ASRS_OFF_PHASE, 8'hff);
    rd("phase", `ASRS_OFF_PHASE, 8'h0f);
    chk("sync", 8'h03, {6'h0, phaseSyncInternal, phaseSyncEn});
    for (int p = 0; p < 4; p++) begin
      wr(`ASRS_OFF_PHASE, 8'(p << 2));
      rd("phase", `ASRS_OFF_PHASE, 8'(p << 2));
      chk("phaseSel", 8'(p), {6'h0, rampPhaseSel});
    end
    wr(`ASRS_OFF_PHASE, 8'h02);
    rd("phase", `ASRS_OFF_PHASE, 8'h02);
    chk("sync", 8'h02, {6'h0, phaseSyncInternal, phaseSyncEn});
    opStateIn = 8'h03;
    rd("state", `ASRS_OFF_PWR, 8'h03);
  endtask
  task automatic t_spread();
    wr(`ASRS_OFF_SS0, 8'hff);
    rd("ss0", `ASRS_OFF_SS0, 8'h33);
    chk("ss0bits", 8'h33, {2'h0, spreadPreDiv, spreadManual, 2'h0,
      randomSpreadOn, triangleSpreadOn});
    chk("mode", 8'(asrs_pkg::ASRS_SS_MANUAL), 8'(spreadMode));
    wr(`ASRS_OFF_SS0, 8'h01);
    rd("ss0", `ASRS_OFF_SS0, 8'h01);
    chk("mode", 8'(asrs_pkg::ASRS_SS_AUTO), 8'(spreadMode));
    wr(`ASRS_OFF_SS0, 8'h02);
    rd("ss0", `ASRS_OFF_SS0, 8'h02);
    chk("mode", 8'(asrs_pkg::ASRS_SS_AUTO), 8'(spreadMode));
    wr(`ASRS_OFF_SS0, 8'h00);
    rd("ss0", `ASRS_OFF_SS0, 8'h00);
    chk("mode", 8'(asrs_pkg::ASRS_SS_OFF), 8'(spreadMode));
  endtask
  task automatic t_fields();
    wr(`ASRS_OFF_SS1, 8'hff);
    wr(`ASRS_OFF_SS2, 8'h01);
    wr(`ASRS_OFF_SS3, 8'h5a);
    wr(`ASRS_OFF_SS4, 8'hff);
    rd("ss1", `ASRS_OFF_SS1, 8'h7f);
    rd("ss2", `ASRS_OFF_SS2, 8'h01);
    rd("ss3", `ASRS_OFF_SS3, 8'h5a);
    rd("ss4", `ASRS_OFF_SS4, 8'h7f);
    chk("trim", 8'h0f, {4'h0, triangleTrimCode});
    chk("dither", 8'h07, {5'h0, ditherAmount});
    chk("divisor", 8'h01, manualFreqDivisor);
    chk("fall", 8'h05, {4'h0, triangleFallStep});
    chk("rise", 8'h0a, {4'h0, triangleRiseStep});
    chk("limit", 8'h1f, {3'h0, trianglePeriodLimit});
    chk("amp", 8'h03, {6'h0, rampAmplitude});
  endtask
  // second reset in mid-run must restore every default
  task automatic t_mid_reset();
    wr(`ASRS_OFF_PHASE, 8'hff);
    wr(`ASRS_OFF_SS0, 8'hff);
    rst_b = 1'b0;
    regWrEn = 1'b0;
    opStateIn = 8'h00;
    {rightMuteIn, leftMuteIn} = 2'h0;
    @(negedge mclk);
    rst_b = 1'b1;
    t_reset_vals();
  endtask
  // ==========================================================
  // run control
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    rst_b = 1'b0;
    regWrEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    opStateIn = 8'h00;
    leftMuteIn = 1'b0;
    rightMuteIn = 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    t_reset_vals();
    t_status();
    t_readonly();
    t_phase();
    t_spread();
    t_fields();
    t_mid_reset();
    test_done();
  end
endmodule
`default_nettype wire
